/* rtl/fscg_pkg.sv */
// Purpose: Constants and types of the flow, suction and compressor guard
// Assumes: Percent inputs are integers, flow in hundredths of a percent
// Notes: Times are counted in tenths of a second; flow times are held in whole seconds
package fscg_pkg;
   // ==========================================
   // Clock and timing
   localparam int CLK_MHZ = 250;
   localparam int TICK_MS = 100;
   localparam int TICKS_PER_SEC = 1000 / TICK_MS;
   localparam int TMR_W = 12;
   localparam int N_TMR = 7;
   // ==========================================
   // Register offsets
   localparam logic [7:0] OFS_FLOW_HI = 8'h00;
   localparam logic [7:0] OFS_FLOW_LO = 8'h04;
   localparam logic [7:0] OFS_FLOW_TM = 8'h08;
   localparam logic [7:0] OFS_SUCT = 8'h0C;
   localparam logic [7:0] OFS_COMP = 8'h10;
   localparam logic [7:0] OFS_MISC = 8'h14;
   localparam logic [7:0] OFS_TARGET = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_STATE = 8'h24;
   // ==========================================
   // Field positions
   localparam int FT_HI_WARN = 0;
   localparam int FT_HI_STOP = 8;
   localparam int FT_LO_WARN = 16;
   localparam int FT_LO_STOP = 24;
   localparam int SC_SEL = 0;
   localparam int SC_REACT = 2;
   localparam int SC_TIME = 4;
   localparam int SC_PID = 16;
   localparam int SC_CUR = 24;
   localparam int CC_LVL = 0;
   localparam int CC_DLY = 8;
   localparam int CC_GAIN = 16;
   localparam int CC_OL = 24;
   localparam int MC_OL_DLY = 0;
   localparam int MC_PSRC = 8;
   localparam int MC_KEYPAD = 9;
   localparam int MC_OPSRC = 10;
   // Event bits of status and mask
   localparam int EV_HI_WARN = 0;
   localparam int EV_HI_STOP = 1;
   localparam int EV_LO_WARN = 2;
   localparam int EV_LO_STOP = 3;
   localparam int EV_SUCT = 4;
   localparam int EV_OL = 5;
   localparam int EV_DERATE = 6;
   localparam int EV_W = 7;
   // ==========================================
   // Reset values
   localparam logic [31:0] RST_FLOW_HI = 32'h0000_26AC;
   localparam logic [31:0] RST_FLOW_LO = 32'h0000_0001;
   localparam logic [31:0] RST_COMP = 32'hC864_14C8;
   localparam logic [31:0] RST_MISC = 32'h0000_02C8;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [15:0] AI_FULL = 16'h0FFF;
   localparam logic [15:0] PCT_FULL = 16'h0064;
   localparam logic [2:0] DER_MAX = 3'h3;
   // ==========================================
   // State machines
   typedef enum logic [3:0] {
      SU_IDLE = 4'b0001, SU_WARN = 4'b0010, SU_FAULT = 4'b0100, SU_RESTART = 4'b1000
   } fscg_suct_e;
   typedef enum logic [2:0] {
      DR_NORMAL = 3'b001, DR_DERATED = 3'b010, DR_LOCKED = 3'b100
   } fscg_der_e;
endpackage : fscg_pkg

/* rtl/fscg_tmr_if.sv */
// Purpose: Start and expiry of one protection timer
// Assumes: Limit in ticks
// Notes: None
`timescale 1ns/100ps
interface fscg_tmr_if #(parameter int W = 12);
   logic run;
   logic [W-1:0] limit;
   logic done;
   modport ctl (output run, output limit, input done);
   modport tmr (input run, input limit, output done);
endinterface : fscg_tmr_if

/* rtl/fscg_timer.sv */
// Purpose: Tick counting timer, restarts whenever run drops
// Assumes: tick_in is a one-cycle pulse
// Notes: done holds until run drops
`timescale 1ns/100ps
module fscg_timer #(
   parameter int W = 12
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Time base
   input wire logic tick_in,
   // Control
   fscg_tmr_if.tmr t
);
   logic [W-1:0] cnt_q;
   logic done_q;

   always_ff @(posedge clk_in) begin
      if (srst_in || !t.run) begin
         cnt_q <= '0;
      end else if (tick_in && !done_q && cnt_q != {W{1'b1}}) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in || !t.run) begin
         done_q <= 1'b0;
      end else if (cnt_q >= t.limit) begin
         done_q <= 1'b1;
      end
   end

   assign t.done = done_q;
endmodule : fscg_timer

/* rtl/fscg_guard.sv */
// Purpose: Flow limit, low suction and compressor overload guard
// Assumes: All inputs synchronous to clk_in
// Notes: Registers over APB, zero wait states
// Function
// - Feedback above max runs high warning timer; expiry raises warning.
// - With warning and feedback above, stop timer expiry sets high stop fault.
// - High warning time zero disables whole high flow function.
// - Feedback compared with settable max and min limits in percent.
// - Feedback below min runs low warning timer; expiry raises warning.
// - With warning and feedback below, stop timer expiry sets low stop fault.
// - Low warning time zero disables low flow function.
// - Suction select: 0 off, 1 PID error, 2 current, 3 both.
// - Condition: PID error above level or current below level.
// - Condition must last longer than detection time before active.
// - Reaction: none, flashing warning, fault, or fault then restart.
// - Target from stored value, or proportional to first analog input.
// - Stored target applies only with keypad target source.
// - Overcurrent at speed for delay multiplies frequency by gain.
// - Current below level restores command frequency, counts one occurrence.
// - After more than three occurrences hold derated frequency until current drops.
// - Current at overload level for delay stops with overload fault.
// - Faults clear with run removed, by reset key or run removal.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module fscg_guard #(
   parameter int TICK_CYC = fscg_pkg::CLK_MHZ * 1000 * fscg_pkg::TICK_MS
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Sensors and drive state
   input wire logic [13:0] flow_fb_in,
   input wire logic [7:0] pid_err_in,
   input wire logic [7:0] motor_cur_in,
   input wire logic [7:0] comp_cur_in,
   input wire logic at_speed_in,
   input wire logic [15:0] freq_cmd_in,
   input wire logic [11:0] first_analog_input_in,
   // Operator
   input wire logic run_cmd_in,
   input wire logic reset_key_in,
   // Commands and indications
   output logic [15:0] freq_out,
   output logic stop_out,
   output logic restart_out,
   output logic [15:0] target_out,
   output logic target_valid_out,
   output logic high_flow_warning_out,
   output logic high_flow_stop_fault_out,
   output logic low_flow_warning_out,
   output logic low_flow_stop_fault_out,
   output logic low_suction_indication_out,
   output logic low_suction_flash_out,
   output logic compressor_overload_stage_two_out,
   output logic irq_out
);
   import fscg_pkg::*;

   function automatic logic [15:0] scale(input logic [15:0] v, input logic [15:0] m,
                                         input logic [15:0] d);
      logic [31:0] p;
      p = {16'h0000, v} * {16'h0000, m};
      scale = 16'(p / {16'h0000, d});
   endfunction : scale

   function automatic logic [TMR_W-1:0] secs(input logic [7:0] s);
      secs = TMR_W'(s * TICKS_PER_SEC);
   endfunction : secs

   // ==========================================
   // Registers
   logic [31:0] flow_hi_q, flow_lo_q, flow_tm_q, suct_q, comp_q, misc_q, tgt_q;
   logic [EV_W-1:0] sts_q, mask_q, mask_d, ev, rd_clr;
   logic [31:0] rdata_q, rd_mux;
   logic err_q, ready_q, hit, wr_en;
   logic run_q, tick_q, flash_q;
   logic [31:0] tick_cnt_q;
   logic hfw_q, hff_q, lfw_q, lff_q, olf_q, restart_q, stop_q, irq_q, lsi_q;
   logic [15:0] freq_q, der_q, tgt_out_q;
   logic tgt_vld_q;
   logic [2:0] der_cnt_q;
   fscg_suct_e su_q;
   fscg_der_e dr_q;
   fscg_tmr_if #(TMR_W) tif [N_TMR] ();

   assign wr_en = psel_in && penable_in && pwrite_in;

   always_comb begin
      hit = 1'b1;
      if (paddr_in == OFS_FLOW_HI) begin
         rd_mux = flow_hi_q;
      end else if (paddr_in == OFS_FLOW_LO) begin
         rd_mux = flow_lo_q;
      end else if (paddr_in == OFS_FLOW_TM) begin
         rd_mux = flow_tm_q;
      end else if (paddr_in == OFS_SUCT) begin
         rd_mux = suct_q;
      end else if (paddr_in == OFS_COMP) begin
         rd_mux = comp_q;
      end else if (paddr_in == OFS_MISC) begin
         rd_mux = misc_q;
      end else if (paddr_in == OFS_TARGET) begin
         rd_mux = tgt_q;
      end else if (paddr_in == OFS_STATUS) begin
         rd_mux = 32'(sts_q);
      end else if (paddr_in == OFS_MASK) begin
         rd_mux = 32'(mask_q);
      end else if (paddr_in == OFS_STATE) begin
         rd_mux = {der_q, 1'b0, der_cnt_q, dr_q, su_q, olf_q, lff_q, lfw_q, hff_q, hfw_q};
      end else begin
         rd_mux = 32'h0000_0000;
         hit = 1'b0;
      end
   end

   // Read data and error prepared in setup
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         ready_q <= 1'b1;
         if (psel_in && !penable_in) begin
            rdata_q <= pwrite_in ? 32'h0000_0000 : rd_mux;
            err_q <= !hit;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         flow_hi_q <= RST_FLOW_HI;
         flow_lo_q <= RST_FLOW_LO;
         flow_tm_q <= RST_ZERO;
         suct_q <= RST_ZERO;
         comp_q <= RST_COMP;
         misc_q <= RST_MISC;
         tgt_q <= RST_ZERO;
         mask_q <= '0;
      end else if (wr_en) begin
         if (paddr_in == OFS_FLOW_HI) begin
            flow_hi_q <= {18'h00000, pwdata_in[13:0]};
         end else if (paddr_in == OFS_FLOW_LO) begin
            flow_lo_q <= {18'h00000, pwdata_in[13:0]};
         end else if (paddr_in == OFS_FLOW_TM) begin
            flow_tm_q <= pwdata_in;
         end else if (paddr_in == OFS_SUCT) begin
            suct_q <= pwdata_in;
         end else if (paddr_in == OFS_COMP) begin
            comp_q <= pwdata_in;
         end else if (paddr_in == OFS_MISC) begin
            misc_q <= {21'h000000, pwdata_in[10:0]};
         end else if (paddr_in == OFS_TARGET) begin
            tgt_q <= {16'h0000, pwdata_in[15:0]};
         end else if (paddr_in == OFS_MASK) begin
            mask_q <= pwdata_in[EV_W-1:0];
         end
      end
   end

   // Read clears only the bits returned; a new event wins
   assign rd_clr = (psel_in && penable_in && !pwrite_in && paddr_in == OFS_STATUS)
                   ? rdata_q[EV_W-1:0] : '0;
   // Interrupt follows a mask write without a cycle of lag
   assign mask_d = (wr_en && paddr_in == OFS_MASK) ? pwdata_in[EV_W-1:0] : mask_q;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         sts_q <= '0;
         irq_q <= 1'b0;
      end else begin
         sts_q <= (sts_q & ~rd_clr) | ev;
         irq_q <= |(((sts_q & ~rd_clr) | ev) & mask_d);
      end
   end

   // ==========================================
   // Time base
   // common tenth tick
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1));
         tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt_q + 1'b1;
      end
   end

   for (genvar i = 0; i < N_TMR; i++) begin : g_tmr
      fscg_timer #(.W(TMR_W)) u_tmr (
         .clk_in(clk_in),
         .srst_in(srst_in),
         .tick_in(tick_q),
         .t(tif[i])
      );
   end

   // ==========================================
   // Flow limits
   logic hi_en, lo_en, above, below, clr_flt;
   assign hi_en = flow_tm_q[FT_HI_WARN+:8] != 8'h00;
   assign lo_en = flow_tm_q[FT_LO_WARN+:8] != 8'h00;
   assign above = flow_fb_in > flow_hi_q[13:0];
   assign below = flow_fb_in < flow_lo_q[13:0];
   assign tif[0].run = hi_en && above && !hfw_q;
   assign tif[0].limit = secs(flow_tm_q[FT_HI_WARN+:8]);
   assign tif[1].run = hi_en && above && hfw_q && !hff_q;
   assign tif[1].limit = secs(flow_tm_q[FT_HI_STOP+:8]);
   assign tif[2].run = lo_en && below && !lfw_q;
   assign tif[2].limit = secs(flow_tm_q[FT_LO_WARN+:8]);
   assign tif[3].run = lo_en && below && lfw_q && !lff_q;
   assign tif[3].limit = secs(flow_tm_q[FT_LO_STOP+:8]);

   assign clr_flt = !run_cmd_in && (misc_q[MC_OPSRC] ? run_q : reset_key_in);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         hfw_q <= 1'b0;
         hff_q <= 1'b0;
         lfw_q <= 1'b0;
         lff_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         run_q <= run_cmd_in;
         hfw_q <= hi_en && (tif[0].done || (hfw_q && above));
         lfw_q <= lo_en && (tif[2].done || (lfw_q && below));
         hff_q <= hi_en && (tif[1].done || (hff_q && !clr_flt));
         lff_q <= lo_en && (tif[3].done || (lff_q && !clr_flt));
      end
   end

   // ==========================================
   // Low suction
   logic su_cond;
   assign su_cond = (suct_q[SC_SEL] && pid_err_in > {3'h0, suct_q[SC_PID+:5]})
                  || (suct_q[SC_SEL+1] && motor_cur_in < {1'b0, suct_q[SC_CUR+:7]});
   assign tif[4].run = su_cond && su_q == SU_IDLE;
   assign tif[4].limit = TMR_W'(suct_q[SC_TIME+:9]) + 1'b1;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         su_q <= SU_IDLE;
      end else begin
         case (su_q)
            SU_IDLE: begin
               if (tif[4].done) begin
                  if (suct_q[SC_REACT+:2] == 2'h1) begin
                     su_q <= SU_WARN;
                  end else if (suct_q[SC_REACT+1]) begin
                     su_q <= SU_FAULT;
                  end
               end
            end
            SU_WARN: begin
               if (!su_cond) begin
                  su_q <= SU_IDLE;
               end
            end
            SU_FAULT: begin
               if (clr_flt) begin
                  su_q <= SU_IDLE;
               end else if (suct_q[SC_REACT] && !su_cond) begin
                  su_q <= SU_RESTART;
               end
            end
            default: begin
               su_q <= SU_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         flash_q <= 1'b0;
      end else if (su_q != SU_WARN) begin
         flash_q <= 1'b0;
      end else if (tick_q) begin
         flash_q <= !flash_q;
      end
   end

   // ==========================================
   // Compressor protection
   logic over_der, step;
   assign over_der = comp_cur_in > comp_q[CC_LVL+:8];
   assign tif[5].run = at_speed_in && over_der && dr_q != DR_LOCKED && !tif[5].done;
   assign tif[5].limit = TMR_W'(comp_q[CC_DLY+:8]);
   assign step = tif[5].done;
   assign tif[6].run = comp_cur_in >= comp_q[CC_OL+:8] && !olf_q;
   assign tif[6].limit = TMR_W'(misc_q[MC_OL_DLY+:8]);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         dr_q <= DR_NORMAL;
         der_q <= 16'h0000;
         der_cnt_q <= 3'h0;
      end else begin
         case (dr_q)
            DR_NORMAL, DR_DERATED: begin
               if (step) begin
                  der_q <= scale(dr_q == DR_NORMAL ? freq_cmd_in : der_q,
                                 {9'h000, comp_q[CC_GAIN+:7]}, PCT_FULL);
                  dr_q <= (der_cnt_q > DER_MAX) ? DR_LOCKED : DR_DERATED;
               end else if (dr_q == DR_DERATED && !over_der) begin
                  dr_q <= DR_NORMAL;
                  der_cnt_q <= (der_cnt_q > DER_MAX) ? der_cnt_q : der_cnt_q + 1'b1;
               end
            end
            default: begin
               if (!over_der) begin
                  dr_q <= DR_NORMAL;
                  der_cnt_q <= 3'h0;
               end
            end
         endcase
      end
   end

   // ==========================================
   // Outputs
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         olf_q <= 1'b0;
         stop_q <= 1'b0;
         restart_q <= 1'b0;
         lsi_q <= 1'b0;
         freq_q <= 16'h0000;
         tgt_out_q <= 16'h0000;
         tgt_vld_q <= 1'b0;
      end else begin
         olf_q <= tif[6].done || (olf_q && !clr_flt);
         stop_q <= hff_q || lff_q || olf_q || su_q == SU_FAULT;
         restart_q <= su_q == SU_RESTART;
         lsi_q <= su_q == SU_WARN || su_q == SU_FAULT;
         freq_q <= (dr_q == DR_NORMAL) ? freq_cmd_in : der_q;
         tgt_vld_q <= misc_q[MC_KEYPAD];
         tgt_out_q <= misc_q[MC_PSRC] ?
                      scale(tgt_q[15:0], {4'h0, first_analog_input_in}, AI_FULL) : tgt_q[15:0];
      end
   end

   assign ev = {step, tif[6].done, tif[4].done, tif[3].done, tif[2].done,
                tif[1].done, tif[0].done};

   assign prdata_out = rdata_q;
   assign pready_out = ready_q;
   assign pslverr_out = err_q;
   assign freq_out = freq_q;
   assign stop_out = stop_q;
   assign restart_out = restart_q;
   assign target_out = tgt_out_q;
   assign target_valid_out = tgt_vld_q;
   assign high_flow_warning_out = hfw_q;
   assign high_flow_stop_fault_out = hff_q;
   assign low_flow_warning_out = lfw_q;
   assign low_flow_stop_fault_out = lff_q;
   assign low_suction_indication_out = lsi_q;
   assign low_suction_flash_out = flash_q;
   assign compressor_overload_stage_two_out = olf_q;
   assign irq_out = irq_q;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   hi_disable_a : assert property (!hi_en |=> !hfw_q && !hff_q)
      else $error("high flow active while disabled");
   hi_stop_order_a : assert property ($rose(hff_q) |-> $past(hfw_q))
      else $error("high stop fault without warning");
   hi_warn_cause_a : assert property ($rose(hfw_q) |-> $past(tif[0].done))
      else $error("high warning without expiry");
   lo_disable_a : assert property (!lo_en |=> !lfw_q && !lff_q)
      else $error("low flow active while disabled");
   lo_stop_order_a : assert property ($rose(lff_q) |-> $past(lfw_q))
      else $error("low stop fault without warning");
   suct_off_a : assert property (suct_q[SC_SEL+:2] == 2'h0 |=> !tif[4].done)
      else $error("suction detected while off");
   freq_restore_a : assert property (dr_q == DR_NORMAL |=> freq_q == $past(freq_cmd_in))
      else $error("frequency not restored");
   ol_stop_a : assert property ($rose(olf_q) |=> stop_q)
      else $error("overload did not stop");
   flt_clear_a : assert property (olf_q && clr_flt && !tif[6].done |=> !olf_q)
      else $error("fault not cleared");
   irq_level_a : assert property (|(sts_q & mask_q) |-> irq_q)
      else $error("interrupt missing");
endmodule : fscg_guard

/* bench/fscg_plant_model.sv */
// Purpose: Sensor and PLC side of the guard
// Assumes: Set points come from the bench
// Notes: The PLC removes run while a stop is reported
`timescale 1ns/100ps
module fscg_plant_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Bench set points
   input wire logic [13:0] flow_set_in,
   input wire logic [7:0] cur_set_in,
   input wire logic run_req_in,
   // Guard outputs
   input wire logic stop_in,
   // Sensor and PLC lines
   output logic [13:0] flow_fb_out,
   output logic [7:0] comp_cur_out,
   output logic run_cmd_out
);
   always_ff @(posedge clk_in) begin
      flow_fb_out <= flow_set_in;
      comp_cur_out <= cur_set_in;
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         run_cmd_out <= 1'b0;
      end else begin
         run_cmd_out <= run_req_in & ~stop_in;
      end
   end
endmodule : fscg_plant_model

/* bench/tb.sv */
// Purpose: Self-checking bench of the guard
// Assumes: Tick shortened to 10 cycles
// Notes: Suction table holds {event, pid, current, config}
`timescale 1ns/100ps
module tb;
   import fscg_pkg::*;
   logic clk_in = 0, srst_in = 1, psel = 0, penable = 0, pwrite = 0, at_speed = 0;
   logic run_req = 1, key = 0, stop_seen = 0, err, v;
   logic [7:0] paddr = 8'h00, pid = 8'h00, mcur = 8'h32, cur = 8'h00, ccur;
   logic [31:0] pwdata = 32'h0, prdata, rd_data;
   logic [13:0] flow = 14'h1388, fb;
   logic [15:0] fcmd = 16'h1770, freq, target;
   logic [11:0] ai = 12'hFFF;
   logic pready, pslverr, stop, restart, tvalid, hfw, hff, lfw, lff, lsi, flash, ol, irq, run;
   logic [48:0] su_tab [6] = '{49'h0_140A_1E0A_0058, 49'h1_1432_1E0A_0059,
      49'h1_000A_1E0A_005A, 49'h0_050A_1E0A_0059, 49'h1_1432_1E0A_0051, 49'h1_000A_1E0A_005B};
   int error_cnt = 0, checks = 0;
   wire logic [7:0] flags = {restart, ol, lsi, lff, lfw, hff, hfw, stop};
   always #2 clk_in = ~clk_in;
   always @(posedge clk_in) if (stop === 1'b1) stop_seen <= 1'b1;
   fscg_guard #(.TICK_CYC(10)) u_fscg_guard (.clk_in(clk_in), .srst_in(srst_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .flow_fb_in(fb), .pid_err_in(pid), .motor_cur_in(mcur), .comp_cur_in(ccur),
      .at_speed_in(at_speed), .freq_cmd_in(fcmd), .first_analog_input_in(ai),
      .run_cmd_in(run), .reset_key_in(key), .freq_out(freq), .stop_out(stop),
      .restart_out(restart), .target_out(target), .target_valid_out(tvalid),
      .high_flow_warning_out(hfw), .high_flow_stop_fault_out(hff),
      .low_flow_warning_out(lfw), .low_flow_stop_fault_out(lff),
      .low_suction_indication_out(lsi), .low_suction_flash_out(flash),
      .compressor_overload_stage_two_out(ol), .irq_out(irq));
   fscg_plant_model u_fscg_plant_model (.clk_in(clk_in), .srst_in(srst_in),
      .flow_set_in(flow), .cur_set_in(cur), .run_req_in(run_req), .stop_in(stop),
      .flow_fb_out(fb), .comp_cur_out(ccur), .run_cmd_out(run));
   task summarize;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : chk
   // One APB transfer, waits for pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1) begin
         @(posedge clk_in);
      end
      rd_data = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      chk(rd_data, exp, msg);
   endtask : rd
   task key_clear;
      @(posedge clk_in);
      key <= 1'b1;
      @(posedge clk_in);
      key <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask : key_clear
   task wait_flag(input int b, input int lim, input string msg);
      int n;
      n = 0;
      while (flags[b] !== 1'b1 && n < lim) begin
         @(posedge clk_in);
         n++;
      end
      chk(flags[b], 1'b1, msg);
   endtask : wait_flag
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      rd(OFS_FLOW_HI, RST_FLOW_HI, "flow max reset");
      rd(OFS_COMP, RST_COMP, "comp reset");
      rd(OFS_MISC, RST_MISC, "misc reset");
      rd(OFS_FLOW_TM, RST_ZERO, "flow time reset");
      apb(1'b1, 8'h3C, 32'h1);
      chk(err, 1'b1, "unmapped error");
      apb(1'b1, OFS_MASK, 32'h7F);
      apb(1'b1, OFS_FLOW_TM, 32'h0000_0500);
      flow <= 14'h26DE;
      repeat (300) @(posedge clk_in);
      chk(flags[2:1], 2'h0, "high flow not disabled");
      apb(1'b1, OFS_FLOW_TM, 32'h0000_0101);
      repeat (50) @(posedge clk_in);
      chk(hfw, 1'b0, "high warning early");
      wait_flag(1, 200, "high warning");
      chk(irq, 1'b1, "irq raised");
      repeat (50) @(posedge clk_in);
      chk(hff, 1'b0, "high stop early");
      wait_flag(2, 200, "high stop");
      flow <= 14'h1388;
      repeat (5) @(posedge clk_in);
      chk(flags[2:0], 3'h5, "fault latch");
      key_clear();
      chk(hff, 1'b0, "key clear");
      rd(OFS_STATUS, 32'h3, "status high");
      rd(OFS_STATUS, 32'h0, "status cleared");
      chk(irq, 1'b0, "irq cleared");
      apb(1'b1, OFS_MASK, 32'h0);
      apb(1'b1, OFS_FLOW_TM, 32'h0100_0000);
      flow <= 14'h0;
      repeat (300) @(posedge clk_in);
      chk(flags[4:3], 2'h0, "low flow not disabled");
      apb(1'b1, OFS_FLOW_TM, 32'h0101_0000);
      repeat (60) @(posedge clk_in);
      flow <= 14'h1388;
      repeat (3) @(posedge clk_in);
      flow <= 14'h0;
      repeat (80) @(posedge clk_in);
      chk(lfw, 1'b0, "low timer restart");
      wait_flag(3, 100, "low warning");
      wait_flag(4, 250, "low stop");
      chk(irq, 1'b0, "irq masked");
      rd(OFS_STATUS, 32'hC, "status low");
      flow <= 14'h1388;
      key_clear();
      chk(lff, 1'b0, "low clear");
      apb(1'b1, OFS_FLOW_TM, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, OFS_STATUS, 32'h0);
         apb(1'b1, OFS_SUCT, su_tab[i][31:0]);
         pid <= su_tab[i][47:40];
         mcur <= su_tab[i][39:32];
         repeat (40) @(posedge clk_in);
         chk(lsi, 1'b0, "suction early");
         repeat (100) @(posedge clk_in);
         v = su_tab[i][48] && su_tab[i][3:2] != 2'h0;
         chk(lsi, v, "suction level");
         chk(stop, v, "suction stop");
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(rd_data[EV_SUCT], su_tab[i][48], "suction event");
         pid <= 8'h0;
         mcur <= 8'h32;
         key_clear();
         chk(lsi, 1'b0, "suction clear");
      end
      apb(1'b1, OFS_SUCT, 32'h1E0A_0055);
      pid <= 8'h14;
      repeat (80) @(posedge clk_in);
      v = flash;
      repeat (10) @(posedge clk_in);
      chk({stop, flash}, {1'b0, ~v}, "suction flash");
      pid <= 8'h0;
      repeat (5) @(posedge clk_in);
      apb(1'b1, OFS_SUCT, 32'h1E0A_005D);
      pid <= 8'h14;
      wait_flag(0, 150, "suction fault");
      pid <= 8'h0;
      wait_flag(7, 100, "suction restart");
      apb(1'b1, OFS_SUCT, 32'h0);
      apb(1'b1, OFS_COMP, 32'hC85A_0A50);
      cur <= 8'h5A;
      repeat (150) @(posedge clk_in);
      chk(freq, 16'h1770, "no derate off speed");
      at_speed <= 1'b1;
      repeat (150) @(posedge clk_in);
      chk(freq, 16'h1518, "derate step");
      repeat (100) @(posedge clk_in);
      chk(freq, 16'h12FC, "derate compound");
      for (int i = 0; i < 5; i++) begin
         cur <= 8'h46;
         repeat (5) @(posedge clk_in);
         chk(freq, 16'h1770, "restore");
         cur <= 8'h5A;
         repeat ((i == 3) ? 350 : 150) @(posedge clk_in);
         chk(freq, 16'h1518, "derate hold");
      end
      cur <= 8'h46;
      repeat (5) @(posedge clk_in);
      chk(freq, 16'h1770, "unlock");
      apb(1'b1, OFS_COMP, 32'h645A_0AC8);
      apb(1'b1, OFS_MISC, 32'h605);
      stop_seen <= 1'b0;
      cur <= 8'h96;
      repeat (40) @(posedge clk_in);
      chk(ol, 1'b0, "overload early");
      wait_flag(6, 100, "overload");
      cur <= 8'h32;
      repeat (6) @(posedge clk_in);
      chk({stop_seen, ol, stop}, 3'h4, "run removal clear");
      apb(1'b1, OFS_TARGET, 32'h3E8);
      apb(1'b1, OFS_MISC, 32'h2C8);
      repeat (3) @(posedge clk_in);
      chk({tvalid, target}, 17'h103E8, "stored target");
      ai <= 12'h800;
      apb(1'b1, OFS_MISC, 32'h1C8);
      repeat (3) @(posedge clk_in);
      chk({tvalid, target}, 17'h001F4, "analog target");
      summarize();
   end
endmodule : tb
